//--- design/pci_bridge_config_header_bars.v
// Configuration header identification words and the two controller decode windows
//
// What this block does
// [RQ1] Class code reads fixed as bridge, host bridge, unused programming interface.
// [RQ2] Dword at 0x0C reads fixed zero header type, single function.
// [RQ3] I/O window bit 0 always reads one; writes to it ignored.
// [RQ4] I/O window reserved bit beside the space bit always reads zero.
// [RQ5] I/O window base field sets the controller's PCI I/O address.
// [RQ6] No PCI I/O decode for the controller while the I/O base is zero.
// [RQ7] Memory window bit 0 always reads zero, marking memory space.
// [RQ8] Memory type bits read zero: place anywhere in 32-bit space.
// [RQ9] Prefetch bit reads zero: controller registers are not prefetchable.
// [RQ10] Memory window base field sets the controller's PCI memory address.
// [RQ11] No PCI memory decode for the controller while the memory base is zero.
// [RQ12] Base bits below window size read zero so software can size windows.
`timescale 1ns/1ps
`include "pci_bridge_config_header_bars_regs.vh"

module pci_bridge_config_header_bars #(
  parameter [7:0] REVISION_ID = 8'h00
) (
  input wire clk_sys,
  input wire arst_n,
  input wire clkEn,
  input wire cfgRead,
  input wire cfgWrite,
  input wire [7:0] cfgAddr,
  input wire [3:0] cfgByteEn,
  input wire [31:0] cfgWrData,
  output reg [31:0] cfgRdData_q,
  output reg cfgAck_q,
  input wire pciIoReq,
  input wire pciMemReq,
  input wire [31:0] pciAddr,
  output wire ioHit_q,
  output wire [`IO_BASE_LSB-1:0] ioOffset_q,
  output wire memHit_q,
  output wire [`MEM_BASE_LSB-1:0] memOffset_q,
  output reg ioDecodeOn_q,
  output reg memDecodeOn_q
);

  // REVISION_ID is an arbitrary neutral value; the revision field is owned elsewhere

  wire [7:0] wordAddr;
  wire cfgAccess;
  wire cfgWriteOnly;
  wire ioWinWr;
  wire memWinWr;
  wire [31:`IO_BASE_LSB] ioBase;
  wire [31:`MEM_BASE_LSB] memBase;
  wire [31:0] ioWinRaw;
  wire [31:0] memWinRaw;
  wire ioWinOn;
  wire memWinOn;
  wire [23:0] classCode;
  reg [31:0] ioWinRead;
  reg [31:0] memWinRead;
  reg [31:0] rdData_d;

  // Byte offset of the addressed dword; the two low address bits never select
  assign wordAddr = {cfgAddr[7:2], 2'b00};

  // A request in the same cycle as a read is treated as the read alone
  assign cfgAccess = cfgRead | cfgWrite;
  assign cfgWriteOnly = cfgWrite & ~cfgRead;

  // [RQ5] I/O base write
  assign ioWinWr = cfgWriteOnly && (wordAddr == `CFG_OFF_IO_BASE_WINDOW);

  // [RQ10] Memory base write
  assign memWinWr = cfgWriteOnly && (wordAddr == `CFG_OFF_MEM_BASE_WINDOW);

  // [RQ1] Fixed class code
  assign classCode = {`CLASS_BASE_BRIDGE, `CLASS_SUB_HOST_BRIDGE, `CLASS_PROG_IF_UNUSED};

  // I/O space window register, base field above the window size only
  cfg_base_window #(
    .BASE_LSB(`IO_BASE_LSB),
    .LOW_FLAGS(`IO_LOW_FLAGS)
  ) u_io_window (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .wrEn(ioWinWr),
    .byteEn(cfgByteEn),
    .wrData(cfgWrData),
    .base_q(ioBase),
    .readValue(ioWinRaw),
    .decodeOn(ioWinOn)
  );

  // Memory space window register
  cfg_base_window #(
    .BASE_LSB(`MEM_BASE_LSB),
    .LOW_FLAGS(`MEM_LOW_FLAGS)
  ) u_mem_window (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .wrEn(memWinWr),
    .byteEn(cfgByteEn),
    .wrData(cfgWrData),
    .base_q(memBase),
    .readValue(memWinRaw),
    .decodeOn(memWinOn)
  );

  // Read view of the I/O window; the flag bits are forced here again so a
  // change of LOW_FLAGS or BASE_LSB cannot make them writable by accident
  always @* begin
    ioWinRead = ioWinRaw;
    // [RQ3] Space bit one
    ioWinRead[`IO_SPACE_BIT] = 1'b1;
    // [RQ4] Reserved bit zero
    ioWinRead[`IO_RESERVED_BIT] = 1'b0;
  end

  // Read view of the memory window
  always @* begin
    memWinRead = memWinRaw;
    // [RQ7] Space bit zero
    memWinRead[`MEM_SPACE_BIT] = 1'b0;
    // [RQ8] Type bits zero
    memWinRead[`MEM_TYPE_LSB + 1] = 1'b0;
    memWinRead[`MEM_TYPE_LSB] = 1'b0;
    // [RQ9] Prefetch bit zero
    memWinRead[`MEM_PREFETCH_BIT] = 1'b0;
  end

  // Configuration read multiplexer; unmapped dwords read as zero
  always @* begin
    rdData_d = `CFG_UNMAPPED_VALUE;
    case (wordAddr)
      `CFG_OFF_CLASS_WORD: begin
        // [RQ1] Class code read
        rdData_d = {classCode, REVISION_ID};
      end
      `CFG_OFF_HEADER_TYPE_WORD: begin
        // [RQ2] Header type read
        rdData_d = `HEADER_TYPE_WORD_VALUE;
      end
      `CFG_OFF_IO_BASE_WINDOW: begin
        // [RQ12] Sizing read-back
        rdData_d = ioWinRead;
      end
      `CFG_OFF_MEM_BASE_WINDOW: begin
        // [RQ12] Sizing read-back
        rdData_d = memWinRead;
      end
      default: begin
        rdData_d = `CFG_UNMAPPED_VALUE;
      end
    endcase
  end

  // Every request taken while clkEn is high is answered one cycle later; read data hold until the next read,
  // so a slow master may sample them late without a second request
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfgRdData_q <= 32'h0000_0000;
      cfgAck_q <= 1'b0;
    end else if (clkEn) begin
      cfgAck_q <= cfgAccess;
      if (cfgRead) begin
        cfgRdData_q <= rdData_d;
      end
    end
  end

  // Decoder enables shown as levels; they follow a base write by one cycle
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ioDecodeOn_q <= 1'b0;
      memDecodeOn_q <= 1'b0;
    end else if (clkEn) begin
      ioDecodeOn_q <= ioWinOn;
      memDecodeOn_q <= memWinOn;
    end
  end

  // [RQ6] I/O decode gate
  window_hit_check #(
    .BASE_LSB(`IO_BASE_LSB)
  ) u_io_hit (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .reqValid(pciIoReq),
    .reqAddr(pciAddr),
    .base(ioBase),
    .decodeOn(ioWinOn),
    .hit_q(ioHit_q),
    .offset_q(ioOffset_q)
  );

  // [RQ11] Memory decode gate
  window_hit_check #(
    .BASE_LSB(`MEM_BASE_LSB)
  ) u_mem_hit (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .reqValid(pciMemReq),
    .reqAddr(pciAddr),
    .base(memBase),
    .decodeOn(memWinOn),
    .hit_q(memHit_q),
    .offset_q(memOffset_q)
  );

endmodule // pci_bridge_config_header_bars

//--- design/pci_bridge_config_header_bars_regs.vh
// Offsets, field layouts and fixed values of the bridge configuration header block
`ifndef PCI_BRIDGE_CONFIG_HEADER_BARS_REGS_VH
`define PCI_BRIDGE_CONFIG_HEADER_BARS_REGS_VH

// Configuration dword byte offsets
`define CFG_OFF_CLASS_WORD 8'h08
`define CFG_OFF_HEADER_TYPE_WORD 8'h0C
`define CFG_OFF_IO_BASE_WINDOW 8'h10
`define CFG_OFF_MEM_BASE_WINDOW 8'h14

// Fixed identification values
`define CLASS_BASE_BRIDGE 8'h06
`define CLASS_SUB_HOST_BRIDGE 8'h00
`define CLASS_PROG_IF_UNUSED 8'h00
`define HEADER_TYPE_SINGLE_FUNC 8'h00
`define HEADER_TYPE_WORD_VALUE 32'h0000_0000

// I/O window: bit 0 space indicator, bit 1 reserved bit
`define IO_SPACE_BIT 0
`define IO_RESERVED_BIT 1
`define IO_LOW_FLAGS 32'h0000_0001
`define IO_BASE_LSB 8

// Memory window: bit 0 space, bits 2:1 memory type bits, bit 3 prefetch
`define MEM_SPACE_BIT 0
`define MEM_TYPE_LSB 1
`define MEM_PREFETCH_BIT 3
`define MEM_LOW_FLAGS 32'h0000_0000
`define MEM_BASE_LSB 18

// Reset value of both writable base fields
`define BASE_WINDOW_RESET 32'h0000_0000

// Read value of an unmapped configuration offset
`define CFG_UNMAPPED_VALUE 32'h0000_0000

`endif

//--- design/cfg_base_window.v
// One base address window register: writable base field over hard-wired low bits
`timescale 1ns/1ps
`include "pci_bridge_config_header_bars_regs.vh"

module cfg_base_window #(
  parameter BASE_LSB = 8,
  parameter [31:0] LOW_FLAGS = 32'h0000_0000
) (
  input wire clk_sys,
  input wire arst_n,
  input wire clkEn,
  input wire wrEn,
  input wire [3:0] byteEn,
  input wire [31:0] wrData,
  output reg [31:BASE_LSB] base_q,
  output wire [31:0] readValue,
  output wire decodeOn
);

  // Full reset word kept at 32 bits so the base field takes an explicit slice of it
  localparam [31:0] RESET_WORD = `BASE_WINDOW_RESET;

  reg [31:BASE_LSB] base_d;
  integer i;

  // Byte lanes merge into the base field; bits below BASE_LSB are never stored
  always @* begin
    base_d = base_q;
    if (wrEn) begin
      for (i = BASE_LSB; i < 32; i = i + 1) begin
        if (byteEn[i / 8]) begin
          base_d[i] = wrData[i];
        end
      end
    end
  end

  // Base field register, frozen while the clock enable is low
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      base_q <= RESET_WORD[31:BASE_LSB];
    end else if (clkEn) begin
      base_q <= base_d;
    end
  end

  // Low bits read as the fixed flags, so all ones written back reveals the size
  assign readValue = {base_q, LOW_FLAGS[BASE_LSB-1:0]};

  // A zero base turns the decoder off
  assign decodeOn = |base_q;

endmodule // cfg_base_window

//--- design/window_hit_check.v
// Registered address compare of one decode window against its base field
`timescale 1ns/1ps

module window_hit_check #(
  parameter BASE_LSB = 8
) (
  input wire clk_sys,
  input wire arst_n,
  input wire clkEn,
  input wire reqValid,
  input wire [31:0] reqAddr,
  input wire [31:BASE_LSB] base,
  input wire decodeOn,
  output reg hit_q,
  output reg [BASE_LSB-1:0] offset_q
);

  wire match;

  // A disabled window never matches, even for an address in the zero page
  assign match = reqValid && decodeOn && (reqAddr[31:BASE_LSB] == base);

  // Hit repeats the match of the last cycle with clkEn high; offset holds until the next hit
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hit_q <= 1'b0;
      offset_q <= {BASE_LSB{1'b0}};
    end else if (clkEn) begin
      hit_q <= match;
      if (match) begin
        offset_q <= reqAddr[BASE_LSB-1:0];
      end
    end
  end

endmodule // window_hit_check

//--- tb/pci_bridge_config_header_bars_checker.sv
// Port assertions for the configuration header and decode window block
`timescale 1ns/1ps
module pci_bridge_config_header_bars_checker (
  input wire clk_sys,
  input wire arst_n,
  input wire clkEn,
  input wire cfgRead,
  input wire cfgWrite,
  input wire [7:0] cfgAddr,
  input wire [3:0] cfgByteEn,
  input wire [31:0] cfgWrData,
  input wire [31:0] cfgRdData_q,
  input wire cfgAck_q,
  input wire pciIoReq,
  input wire pciMemReq,
  input wire [31:0] pciAddr,
  input wire ioHit_q,
  input wire [7:0] ioOffset_q,
  input wire memHit_q,
  input wire [17:0] memOffset_q,
  input wire ioDecodeOn_q,
  input wire memDecodeOn_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Read strobe taken this edge; low address bits kept for offset checks
  wire rdTaken = clkEn && cfgRead;
  wire [7:0] ioLow = pciAddr[7:0];
  wire [17:0] memLow = pciAddr[17:0];
  a_class_read: assert property (rdTaken && cfgAddr[7:2] == 6'h02 |=> cfgRdData_q[31:8] == 24'h06_0000)
    else $error("class code read wrong");
  a_header_zero: assert property (rdTaken && cfgAddr[7:2] == 6'h03 |=> cfgRdData_q == 32'h0000_0000)
    else $error("header type read wrong");
  a_io_low_bits: assert property (rdTaken && cfgAddr[7:2] == 6'h04 |=> cfgRdData_q[7:0] == 8'h01)
    else $error("io window low bits wrong");
  a_mem_low_bits: assert property (rdTaken && cfgAddr[7:2] == 6'h05 |=> cfgRdData_q[17:0] == 18'h0_0000)
    else $error("mem window low bits wrong");
  a_io_hit_gated: assert property (ioHit_q |-> ioDecodeOn_q)
    else $error("io hit with zero base");
  a_mem_hit_gated: assert property (memHit_q |-> memDecodeOn_q)
    else $error("mem hit with zero base");
  a_io_hit_cause: assert property ($past(clkEn) && ioHit_q |-> $past(pciIoReq) && ioOffset_q == $past(ioLow))
    else $error("io hit without matching request");
  a_mem_hit_cause: assert property ($past(clkEn) && memHit_q |-> $past(pciMemReq) && memOffset_q == $past(memLow))
    else $error("mem hit without matching request");
  c_io_hit: cover property (ioHit_q);
  c_mem_hit: cover property (memHit_q);
  c_io_sizing: cover property (cfgAck_q && cfgRdData_q == 32'hFFFF_FF01);
endmodule // pci_bridge_config_header_bars_checker

bind pci_bridge_config_header_bars pci_bridge_config_header_bars_checker chk_i (.clk_sys, .arst_n,
  .clkEn, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData_q, .cfgAck_q,
  .pciIoReq, .pciMemReq, .pciAddr, .ioHit_q, .ioOffset_q, .memHit_q, .memOffset_q,
  .ioDecodeOn_q, .memDecodeOn_q);

//--- tb/cfg_master_model.sv
// Configuration master model: one strobe cycle per request, bounded wait for the answer
`timescale 1ns/1ps
module cfg_master_model (
  input wire clk_sys,
  input wire [31:0] cfgRdData_q,
  input wire cfgAck_q,
  output logic cfgRead,
  output logic cfgWrite,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWrData
);
  int hangs = 0;
  // Lines are inverted after the strobe so a stale value can never pass a check
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk_sys) #1;
    {cfgRead, cfgWrite, cfgAddr, cfgWrData, cfgByteEn} = {!wr, wr, a, d, be};
    @(posedge clk_sys) #1;
    {cfgRead, cfgWrite, cfgAddr, cfgWrData, cfgByteEn} = {2'b00, ~a, ~d, ~be};
    for (n = 0; n < 8 && cfgAck_q !== 1'b1; n++) @(posedge clk_sys) #1;
    if (n == 8) hangs++;
    q = cfgRdData_q;
  endtask
  initial {cfgRead, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = '0;
endmodule // cfg_master_model

//--- tb/pci_bridge_config_header_bars_test.sv
// Self-checking bench for the identification words and the two decode windows
`timescale 1ns/1ps
module pci_bridge_config_header_bars_test;
  logic clk_sys = 0, arst_n = 0, pciIoReq = 0, pciMemReq = 0, clkEn = 1;
  logic [31:0] pciAddr = '0, cfgWrData, cfgRdData_q, rd;
  logic cfgRead, cfgWrite, cfgAck_q, ioHit_q, memHit_q, ioDecodeOn_q, memDecodeOn_q;
  logic [7:0] cfgAddr, ioOffset_q;
  logic [3:0] cfgByteEn;
  logic [17:0] memOffset_q;
  int miscompares = 0, n_compared = 0;
  initial forever #20 clk_sys = ~clk_sys;
  // Clock enable driven by the bench so one scenario can stall the block
  pci_bridge_config_header_bars dut (.clk_sys, .arst_n, .clkEn, .cfgRead, .cfgWrite,
    .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData_q, .cfgAck_q, .pciIoReq, .pciMemReq, .pciAddr,
    .ioHit_q, .ioOffset_q, .memHit_q, .memOffset_q, .ioDecodeOn_q, .memDecodeOn_q);
  cfg_master_model cfg (.clk_sys, .cfgRdData_q, .cfgAck_q, .cfgRead, .cfgWrite, .cfgAddr,
    .cfgByteEn, .cfgWrData);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    cfg.xfer(1, a, d, be, rd);
    if (cfg.hangs != 0) stop_test();
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    cfg.xfer(0, a, 32'h0000_0000, 4'h0, rd);
    if (cfg.hangs != 0) stop_test();
    chk($sformatf("offset %h", a), exp, rd);
  endtask
  // One decode cycle; hits = {io, mem} expected one cycle later
  task automatic pci(input logic io, input logic mem, input logic [31:0] a, input logic [1:0] hits);
    @(posedge clk_sys) #1;
    {pciIoReq, pciMemReq, pciAddr} = {io, mem, a};
    @(posedge clk_sys) #1;
    {pciIoReq, pciMemReq, pciAddr} = {2'b00, ~a};
    chk("hits", {30'h0, hits}, {30'h0, ioHit_q, memHit_q});
    if (hits[1]) chk("io offset", {24'h0, a[7:0]}, {24'h0, ioOffset_q});
    if (hits[0]) chk("mem offset", {14'h0, a[17:0]}, {14'h0, memOffset_q});
  endtask
  task automatic stop_test();
    miscompares += cfg.hangs;
    $display("Counts: %0d compared, %0d mismatched", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 arst_n = 1;
    repeat (2) @(posedge clk_sys);
    wr(8'h08, 32'hFFFF_FFFF, 4'hF);
    wr(8'h0C, 32'hFFFF_FFFF, 4'hF);
    rdchk(8'h08, 32'h0600_0000);
    rdchk(8'h0C, 32'h0000_0000);
    rdchk(8'h10, 32'h0000_0001);
    rdchk(8'h14, 32'h0000_0000);
    rdchk(8'h20, 32'h0000_0000);
    $display("Test identification done");
    wr(8'h10, 32'hFFFF_FFFF, 4'hF);
    rdchk(8'h10, 32'hFFFF_FF01);
    wr(8'h14, 32'hFFFF_FFFF, 4'hF);
    rdchk(8'h14, 32'hFFFC_0000);
    wr(8'h14, 32'h0000_0000, 4'h8);
    rdchk(8'h14, 32'h00FC_0000);
    $display("Test sizing done");
    wr(8'h10, 32'h0000_1200, 4'hF);
    wr(8'h14, 32'h0004_0000, 4'hF);
    rdchk(8'h10, 32'h0000_1201);
    chk("decode on", 32'h0000_0003, {30'h0, ioDecodeOn_q, memDecodeOn_q});
    pci(1, 0, 32'h0000_1234, 2'b10);
    pci(1, 0, 32'h0000_1334, 2'b00);
    pci(0, 1, 32'h0005_1234, 2'b01);
    pci(1, 1, 32'h0008_1234, 2'b00);
    // Frozen block must not answer a matching address, and must keep its base
    clkEn = 0;
    pci(1, 0, 32'h0000_1234, 2'b00);
    clkEn = 1;
    pci(1, 0, 32'h0000_1256, 2'b10);
    $display("Test decode done");
    wr(8'h10, 32'h0000_0000, 4'hF);
    wr(8'h14, 32'h0000_0000, 4'hF);
    repeat (2) @(posedge clk_sys);
    chk("decode on", 32'h0000_0000, {30'h0, ioDecodeOn_q, memDecodeOn_q});
    pci(1, 1, 32'h0000_0010, 2'b00);
    $display("Test zero base done");
    stop_test();
  end
endmodule // pci_bridge_config_header_bars_test
